// file: hw/tcsr_pkg.sv
// Behaviour
// [RULE_01] one mask enable bit per channel
// [RULE_02] sequence converts X, Y, Z1, Z2, AUX
// [RULE_03] single conversion channel from command field
// [RULE_04] sequence code converts every enabled channel
// [RULE_05] done flag set at end, cleared by data read; the code does not set it at the end in pen detect mode
// [RULE_06] pen flag cleared by status read
// [RULE_07] pen flag set only in pen detect mode
// [RULE_08] reset flag reads one after reset
// [RULE_09] key 0xde resets the whole device
// [RULE_10] any other key value does nothing
// [RULE_11] host writes and reads control registers
// [RULE_12] empty buffer or no pen returns 0xffff
// [RULE_13] completion drives interrupt low with done flag; the code does not drive it low at the end in pen detect mode
// [RULE_14] reserved mask bits ignore writes, read zero
package tcsr_pkg;

    // ****************************************
    // register addresses and fields
    // ****************************************
    localparam logic [4:0] ADDR_CHAN_MASK  = 5'h04;
    localparam logic [4:0] ADDR_STATUS     = 5'h05;
    localparam logic [4:0] ADDR_SOFT_RESET = 5'h1f;

    localparam int BIT_X_EN    = 7;
    localparam int BIT_Y_EN    = 6;
    localparam int BIT_P1_EN   = 5;
    localparam int BIT_P2_EN   = 4;
    localparam int BIT_AUX_EN  = 3;
    localparam logic [7:0] CHAN_MASK_WMASK = 8'hf8;
    localparam logic [7:0] CHAN_MASK_RESET = 8'hc0;
    localparam logic [7:0] SOFT_KEY_RESET  = 8'h00;
    localparam logic [7:0] SOFT_RESET_KEY  = 8'hde;

    localparam int BIT_CONV_DONE = 7;
    localparam int BIT_PEN_DET   = 6;
    localparam int BIT_RST_EVT   = 5;

    // ****************************************
    // command byte: opcode [7:5], field [4:0]
    // ****************************************
    localparam logic [2:0] OP_WRITE_REG = 3'h0;
    localparam logic [2:0] OP_READ_REG  = 3'h2;
    localparam logic [2:0] OP_READ_DATA = 3'h1;
    localparam logic [2:0] OP_CONVERT   = 3'h4;

    // channel codes, also sequencing index
    localparam logic [2:0] CHAN_X   = 3'h0;
    localparam logic [2:0] CHAN_Y   = 3'h1;
    localparam logic [2:0] CHAN_P1  = 3'h2;
    localparam logic [2:0] CHAN_P2  = 3'h3;
    localparam logic [2:0] CHAN_AUX = 3'h4;
    localparam logic [2:0] SEQUENCE_CODE = 3'h7;
    localparam int NUM_CHAN = 5;

    localparam logic [15:0] INVALID_DATA = 16'hffff;

    // operating modes
    localparam logic [1:0] MODE_MANUAL  = 2'h0;
    localparam logic [1:0] MODE_AUTO    = 2'h1;
    localparam logic [1:0] MODE_PENDET  = 2'h2;
    localparam logic [1:0] MODE_PENTRIG = 2'h3;

    // counts of serial clock edges
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] WORD_LAST = 4'hf;

    typedef enum logic [1:0] {
        TCSR_IDLE = 2'b00,
        TCSR_REQ  = 2'b01,
        TCSR_WAIT = 2'b11,
        TCSR_NEXT = 2'b10
    } tcsr_state_t;

    typedef struct packed {
        logic       start;
        logic [2:0] chan;
    } tcsr_adc_req_t;

    typedef struct packed {
        logic        done;
        logic [11:0] data;
    } tcsr_adc_rsp_t;

endpackage

// file: hw/tcsr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tcsr_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    // levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    stage1_reg[g] <= 1'b0;
                    stage2_reg[g] <= 1'b0;
                end else begin
                    stage1_reg[g] <= async_i[g];
                    stage2_reg[g] <= stage1_reg[g];
                end
            end
        end
    endgenerate

    assign sync_o = stage2_reg;

endmodule
`default_nettype wire

// file: hw/tcsr_top.sv
`timescale 1ns/100ps
`default_nettype none
module tcsr_top (
    // clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    rst_n_i,
    // serial host link
    input  wire logic                    spi_cs_n_i,
    input  wire logic                    spi_sclk_i,
    input  wire logic                    spi_mosi_i,
    output logic                         spi_miso_o,
    output logic                         spi_miso_oe_o,
    // converter side
    output tcsr_pkg::tcsr_adc_req_t      adc_req_o,
    input  wire tcsr_pkg::tcsr_adc_rsp_t adc_rsp_i,
    // analog status and mode
    input  wire logic                    pen_present_i,
    input  wire logic                    pen_touch_i,
    input  wire logic [1:0]              mode_i,
    input  wire logic                    seq_trigger_i,
    // interrupt
    output logic                         interrupt_out_n_o
);

    // ****************************************
    // synchronisers and soft reset
    // ****************************************
    logic [4:0] pins_s;
    logic       soft_pulse_reg;
    logic       srst_n;

    tcsr_sync #(.WIDTH(5)) u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i ({~spi_cs_n_i, spi_sclk_i, spi_mosi_i,
                   pen_present_i, pen_touch_i}),
        .sync_o  (pins_s)
    );

    // select synced inverted so reset reads as idle, not a frame
    wire cs_n_s  = ~pins_s[4];
    wire sclk_s  = pins_s[3];
    wire mosi_s  = pins_s[2];
    wire pen_s   = pins_s[1];
    wire touch_s = pins_s[0];

    // pulse lasts one cycle, then clears itself
    assign srst_n = rst_n_i & ~soft_pulse_reg; // RULE_09

    // ****************************************
    // serial framing
    // ****************************************
    logic        sclk_d_reg;
    logic        touch_d_reg;
    logic [3:0]  bit_cnt_reg;
    logic        cmd_phase_reg;
    logic [7:0]  rx_sr_reg;
    logic [7:0]  cmd_reg;
    logic [15:0] tx_sr_reg;
    logic        miso_reg;

    wire sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
    wire sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
    wire [7:0] rx_byte  = {rx_sr_reg[6:0], mosi_s};
    wire byte_end = sclk_rise & (bit_cnt_reg == tcsr_pkg::BYTE_LAST);
    wire word_end = sclk_rise & (bit_cnt_reg == tcsr_pkg::WORD_LAST);
    wire cmd_end  = byte_end & cmd_phase_reg;

    wire [2:0] op_new  = rx_byte[7:5];
    wire [2:0] op_held = cmd_reg[7:5];
    wire [4:0] addr    = cmd_reg[4:0];

    wire rd_reg_cmd  = cmd_end & (op_new == tcsr_pkg::OP_READ_REG);
    wire rd_data_cmd = cmd_end & (op_new == tcsr_pkg::OP_READ_DATA);
    wire conv_cmd    = cmd_end & (op_new == tcsr_pkg::OP_CONVERT);
    wire data_word   = ~cmd_phase_reg & word_end &
                       (op_held == tcsr_pkg::OP_READ_DATA);
    wire wr_data     = ~cmd_phase_reg & byte_end &
                       (op_held == tcsr_pkg::OP_WRITE_REG); // RULE_11
    wire wr_mask  = wr_data & (addr == tcsr_pkg::ADDR_CHAN_MASK);
    wire wr_soft  = wr_data & (addr == tcsr_pkg::ADDR_SOFT_RESET);
    // other key values fall through untouched
    wire soft_hit = wr_soft & (rx_byte == tcsr_pkg::SOFT_RESET_KEY); // RULE_10

    wire [4:0] rd_addr_new = rx_byte[4:0];
    wire rd_status = rd_reg_cmd & (rd_addr_new == tcsr_pkg::ADDR_STATUS);

    // counters keep running on to the next byte or word
    wire [3:0] bit_cnt_next = byte_end & cmd_phase_reg ? 4'h0 :
                              word_end ? 4'h0 :
                              sclk_rise ? bit_cnt_reg + 4'h1 : bit_cnt_reg;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            soft_pulse_reg <= 1'b0;
        end else begin
            soft_pulse_reg <= soft_hit; // RULE_09
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!srst_n || cs_n_s) begin
            bit_cnt_reg   <= 4'h0;
            cmd_phase_reg <= 1'b1;
            rx_sr_reg     <= 8'h00;
            cmd_reg       <= 8'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            if (sclk_rise) begin
                rx_sr_reg <= rx_byte;
            end
            if (cmd_end) begin
                cmd_reg       <= rx_byte;
                cmd_phase_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sclk_d_reg  <= 1'b0;
            touch_d_reg <= 1'b0;
        end else begin
            sclk_d_reg  <= sclk_s;
            touch_d_reg <= touch_s;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] mask_reg;
    logic       conv_done_flag_reg;
    logic       pen_flag_reg;
    logic       rst_flag_reg;
    logic       seq_end;

    wire [7:0] status_rd = {conv_done_flag_reg, pen_flag_reg,
                            rst_flag_reg, 5'h00}; // RULE_08
    wire [7:0] reg_rd = (rd_addr_new == tcsr_pkg::ADDR_CHAN_MASK) ?
                        mask_reg :
                        (rd_addr_new == tcsr_pkg::ADDR_STATUS) ?
                        status_rd : 8'h00;

    wire pen_evt = touch_s & ~touch_d_reg &
                   (mode_i == tcsr_pkg::MODE_PENDET); // RULE_07
    wire conv_set = seq_end & (mode_i != tcsr_pkg::MODE_PENDET); // RULE_13

    always_ff @(posedge mclk_i) begin
        if (!srst_n) begin
            mask_reg           <= tcsr_pkg::CHAN_MASK_RESET;
            conv_done_flag_reg <= 1'b0;
            pen_flag_reg       <= 1'b0;
            rst_flag_reg       <= 1'b1; // RULE_08
        end else begin
            if (wr_mask) begin
                mask_reg <= rx_byte & tcsr_pkg::CHAN_MASK_WMASK; // RULE_14
            end
            // set wins over clear on every flag
            if (conv_set) begin
                conv_done_flag_reg <= 1'b1; // RULE_05
            end else if (rd_data_cmd) begin
                conv_done_flag_reg <= 1'b0; // RULE_05
            end
            if (pen_evt) begin
                pen_flag_reg <= 1'b1; // RULE_06
            end else if (rd_status) begin
                pen_flag_reg <= 1'b0; // RULE_06
            end
            if (rd_status) begin
                rst_flag_reg <= 1'b0;
            end
        end
    end

    assign interrupt_out_n_o = ~(conv_done_flag_reg | pen_flag_reg); // RULE_13

    // ****************************************
    // sequencer
    // ****************************************
    function automatic logic [4:0] code_to_set(input logic [2:0] code);
        logic [4:0] s;
        s = 5'h00;
        if (code < 3'(tcsr_pkg::NUM_CHAN)) begin
            s[code] = 1'b1;
        end
        return s;
    endfunction

    function automatic logic [2:0] first_pending(input logic [4:0] p);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = tcsr_pkg::NUM_CHAN - 1; i >= 0; i--) begin
            if (p[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    tcsr_pkg::tcsr_state_t state_reg;
    tcsr_pkg::tcsr_state_t state_next;
    logic [4:0]  pending_reg;
    logic [2:0]  cur_reg;
    logic [15:0] buf_reg [tcsr_pkg::NUM_CHAN];
    logic [2:0]  wr_cnt_reg;
    logic [2:0]  rd_ptr_reg;

    wire [4:0] mask_set = {mask_reg[tcsr_pkg::BIT_AUX_EN],
                           mask_reg[tcsr_pkg::BIT_P2_EN],
                           mask_reg[tcsr_pkg::BIT_P1_EN],
                           mask_reg[tcsr_pkg::BIT_Y_EN],
                           mask_reg[tcsr_pkg::BIT_X_EN]}; // RULE_01
    wire [2:0] chan_field = rx_byte[2:0];
    wire [4:0] start_set = seq_trigger_i ? mask_set :
                           (chan_field == tcsr_pkg::SEQUENCE_CODE) ?
                           mask_set : // RULE_04
                           code_to_set(chan_field); // RULE_03
    // a pending interrupt blocks any new acquisition
    wire start_req = (conv_cmd | seq_trigger_i) & interrupt_out_n_o &
                     (state_reg == tcsr_pkg::TCSR_IDLE);
    wire [4:0] pend_left = pending_reg & ~code_to_set(cur_reg);
    wire [15:0] sample = pen_s ?
                         {1'b0, cur_reg, adc_rsp_i.data} :
                         tcsr_pkg::INVALID_DATA; // RULE_12

    always_comb begin
        state_next = state_reg;
        seq_end    = 1'b0;
        case (state_reg)
            tcsr_pkg::TCSR_IDLE: begin
                if (start_req) begin
                    state_next = tcsr_pkg::TCSR_NEXT;
                end
            end
            tcsr_pkg::TCSR_REQ: begin
                state_next = tcsr_pkg::TCSR_WAIT;
            end
            tcsr_pkg::TCSR_WAIT: begin
                if (adc_rsp_i.done) begin
                    state_next = tcsr_pkg::TCSR_NEXT;
                end
            end
            tcsr_pkg::TCSR_NEXT: begin
                if (pending_reg == 5'h00) begin
                    seq_end    = 1'b1;
                    state_next = tcsr_pkg::TCSR_IDLE;
                end else begin
                    state_next = tcsr_pkg::TCSR_REQ;
                end
            end
            default: begin
                state_next = tcsr_pkg::TCSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!srst_n) begin
            state_reg   <= tcsr_pkg::TCSR_IDLE;
            pending_reg <= 5'h00;
            cur_reg     <= tcsr_pkg::CHAN_X;
            wr_cnt_reg  <= 3'h0;
        end else begin
            state_reg <= state_next;
            if (start_req) begin
                pending_reg <= start_set;
                wr_cnt_reg  <= 3'h0;
            end
            if (state_reg == tcsr_pkg::TCSR_NEXT) begin
                cur_reg <= first_pending(pending_reg); // RULE_02
            end
            if (state_reg == tcsr_pkg::TCSR_WAIT && adc_rsp_i.done) begin
                pending_reg <= pend_left; // RULE_02
                wr_cnt_reg  <= wr_cnt_reg + 3'h1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < tcsr_pkg::NUM_CHAN; g = g + 1) begin : g_buf
            always_ff @(posedge mclk_i) begin
                if (!srst_n) begin
                    buf_reg[g] <= tcsr_pkg::INVALID_DATA;
                end else if (state_reg == tcsr_pkg::TCSR_WAIT &&
                             adc_rsp_i.done && wr_cnt_reg == 3'(g)) begin
                    buf_reg[g] <= sample;
                end
            end
        end
    endgenerate

    assign adc_req_o.start = (state_reg == tcsr_pkg::TCSR_REQ);
    assign adc_req_o.chan  = cur_reg;

    // ****************************************
    // serial answer path
    // ****************************************
    wire load_word = rd_data_cmd | data_word;
    wire have_word = rd_ptr_reg < wr_cnt_reg;
    wire [15:0] next_word = have_word ? buf_reg[rd_ptr_reg] :
                            tcsr_pkg::INVALID_DATA; // RULE_12

    always_ff @(posedge mclk_i) begin
        if (!srst_n) begin
            tx_sr_reg  <= 16'h0000;
            miso_reg   <= 1'b0;
            rd_ptr_reg <= 3'h0;
        end else begin
            if (start_req) begin
                rd_ptr_reg <= 3'h0;
            end else if (load_word && have_word) begin
                rd_ptr_reg <= rd_ptr_reg + 3'h1;
            end
            if (rd_reg_cmd) begin
                tx_sr_reg <= {reg_rd, 8'h00}; // RULE_11
            end else if (load_word) begin
                tx_sr_reg <= next_word;
            end else if (sclk_fall) begin
                miso_reg  <= tx_sr_reg[15];
                tx_sr_reg <= {tx_sr_reg[14:0], 1'b0};
            end
            if (cs_n_s) begin
                miso_reg <= 1'b0;
            end
        end
    end

    assign spi_miso_o    = miso_reg;
    assign spi_miso_oe_o = ~cs_n_s;

endmodule
`default_nettype wire

// file: verif/tcsr_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module tcsr_top_chk (
    // clock and reset
    input wire logic                    mclk_i,
    input wire logic                    rst_n_i,
    // serial host link
    input wire logic                    spi_cs_n_i,
    input wire logic                    spi_sclk_i,
    input wire logic                    spi_mosi_i,
    input wire logic                    spi_miso_o,
    input wire logic                    spi_miso_oe_o,
    // converter, status and interrupt
    input wire tcsr_pkg::tcsr_adc_req_t adc_req_o,
    input wire tcsr_pkg::tcsr_adc_rsp_t adc_rsp_i,
    input wire logic                    pen_present_i,
    input wire logic                    pen_touch_i,
    input wire logic [1:0]              mode_i,
    input wire logic                    seq_trigger_i,
    input wire logic                    interrupt_out_n_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // ****************************************
    // sequence tracking
    // ****************************************
    logic       in_seq_reg;
    logic [2:0] last_chan_reg;

    // a falling interrupt closes the run, so the next start begins afresh
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !interrupt_out_n_o) begin
            in_seq_reg <= 1'b0;
        end else if (adc_req_o.start) begin
            in_seq_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (adc_req_o.start) begin
            last_chan_reg <= adc_req_o.chan;
        end
    end

    sequence s_cs_idle;
        spi_cs_n_i [*4];
    endsequence
    sequence s_cs_busy;
        !spi_cs_n_i [*4];
    endsequence

    property p_miso_idle;
        s_cs_idle |-> !spi_miso_o;
    endproperty
    property p_oe_frame;
        (s_cs_busy |-> spi_miso_oe_o) and (s_cs_idle |-> !spi_miso_oe_o);
    endproperty
    property p_start_pulse;
        adc_req_o.start |=> !adc_req_o.start;
    endproperty
    property p_start_chan;
        adc_req_o.start |-> adc_req_o.chan <= tcsr_pkg::CHAN_AUX;
    endproperty
    property p_order;
        adc_req_o.start && in_seq_reg |-> adc_req_o.chan > last_chan_reg;
    endproperty
    property p_gap;
        adc_rsp_i.done |=> !adc_req_o.start;
    endproperty
    property p_irq_release;
        $rose(rst_n_i) |-> interrupt_out_n_o;
    endproperty
    property p_quiet_reset;
        $rose(rst_n_i) |-> !adc_req_o.start [*3];
    endproperty

    a_miso_idle: assert property (p_miso_idle)
        else $error("miso high outside a frame");
    a_oe_frame: assert property (p_oe_frame)
        else $error("miso enable does not follow chip select");
    a_start_pulse: assert property (p_start_pulse)
        else $error("start longer than one cycle");
    a_start_chan: assert property (p_start_chan)
        else $error("start with channel out of range");
    a_order: assert property (p_order)
        else $error("sequenced channel out of order");
    a_gap: assert property (p_gap)
        else $error("start right after done");
    a_irq_release: assert property (p_irq_release)
        else $error("interrupt low after reset");
    a_quiet_reset: assert property (p_quiet_reset)
        else $error("conversion started after reset");
endmodule
bind tcsr_top tcsr_top_chk u_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_sclk_i(spi_sclk_i), .spi_mosi_i(spi_mosi_i),
    .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
    .adc_req_o(adc_req_o), .adc_rsp_i(adc_rsp_i),
    .pen_present_i(pen_present_i), .pen_touch_i(pen_touch_i),
    .mode_i(mode_i), .seq_trigger_i(seq_trigger_i),
    .interrupt_out_n_o(interrupt_out_n_o)
);
`default_nettype wire

// file: verif/tcsr_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module tcsr_adc_model (
    // clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    rst_n_i,
    // pace
    input  wire logic                    slow_i,
    // converter link
    input  wire tcsr_pkg::tcsr_adc_req_t req_i,
    output tcsr_pkg::tcsr_adc_rsp_t      rsp_o
);
    logic [5:0] wait_reg;
    logic       busy_reg;
    logic [2:0] chan_reg;

    // data toggles outside done so a stale value is never mistaken
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            busy_reg <= 1'b0;
            wait_reg <= 6'h00;
            rsp_o    <= '0;
        end else begin
            rsp_o.done <= 1'b0;
            rsp_o.data <= ~rsp_o.data;
            if (req_i.start) begin
                busy_reg <= 1'b1;
                chan_reg <= req_i.chan;
                wait_reg <= slow_i ? 6'h28 : 6'h00;
            end else if (busy_reg && wait_reg == 6'h00) begin
                busy_reg   <= 1'b0;
                rsp_o.done <= 1'b1;
                rsp_o.data <= {chan_reg, 9'h0a5};
            end else if (wait_reg != 6'h00) begin
                wait_reg <= wait_reg - 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/touch_channel_select_status_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module touch_channel_select_status_regs_tb;
    logic                    mclk_i;
    logic                    rst_n_i;
    logic                    spi_cs_n_i;
    logic                    spi_sclk_i;
    logic                    spi_mosi_i;
    logic                    spi_miso_o;
    logic                    spi_miso_oe_o;
    tcsr_pkg::tcsr_adc_req_t adc_req_o;
    tcsr_pkg::tcsr_adc_rsp_t adc_rsp_i;
    logic                    pen_present_i;
    logic                    pen_touch_i;
    logic [1:0]              mode_i;
    logic                    seq_trigger_i;
    logic                    interrupt_out_n_o;
    logic                    slow;
    logic [7:0]              rb;
    logic [7:0]              m;
    logic [15:0]             got_w [6];
    int                      errors;
    int                      total_checks;
    int                      cycles;
    int                      n;

    tcsr_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i),
        .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o),
        .spi_miso_oe_o(spi_miso_oe_o), .adc_req_o(adc_req_o),
        .adc_rsp_i(adc_rsp_i), .pen_present_i(pen_present_i),
        .pen_touch_i(pen_touch_i), .mode_i(mode_i),
        .seq_trigger_i(seq_trigger_i),
        .interrupt_out_n_o(interrupt_out_n_o));
    tcsr_adc_model u_adc (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .slow_i(slow), .req_i(adc_req_o), .rsp_o(adc_rsp_i));

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    // ****************************************
    // host access tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_i);
    endtask
    // one serial bit per 8 clocks; read late in the high phase
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi_i <= tx[i];
            cyc(4);
            spi_sclk_i <= 1'b1;
            cyc(3);
            @(negedge mclk_i);
            rx[i] = spi_miso_o;
            @(posedge mclk_i);
            spi_sclk_i <= 1'b0;
        end
    endtask
    task automatic frame(input logic [7:0] cmd, input logic [7:0] d,
                         input int nb, output logic [7:0] rx);
        logic [7:0] j;
        spi_cs_n_i <= 1'b0;
        cyc(4);
        xbyte(cmd, j);
        for (int i = 0; i < nb; i++) begin
            xbyte(d, rx);
        end
        cyc(4);
        spi_cs_n_i <= 1'b1;
        cyc(8);
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        frame({tcsr_pkg::OP_WRITE_REG, a}, d, 1, rb);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        frame({tcsr_pkg::OP_READ_REG, a}, 8'h00, 1, rb);
        chk({8'h00, rb}, {8'h00, exp}, "register read");
    endtask
    task automatic convert(input logic [2:0] c);
        frame({tcsr_pkg::OP_CONVERT, 2'h0, c}, 8'h00, 0, rb);
    endtask
    task automatic rd_data(input int k);
        logic [7:0] hi;
        logic [7:0] lo;
        spi_cs_n_i <= 1'b0;
        cyc(4);
        xbyte({tcsr_pkg::OP_READ_DATA, 5'h00}, hi);
        for (int i = 0; i < k; i++) begin
            xbyte(8'h00, hi);
            xbyte(8'h00, lo);
            got_w[i] = {hi, lo};
        end
        cyc(4);
        spi_cs_n_i <= 1'b1;
        cyc(8);
    endtask
    task automatic wait_irq(input logic lvl);
        int k;
        k = 0;
        while (interrupt_out_n_o !== lvl && k < 4000) begin
            @(negedge mclk_i);
            k++;
        end
        chk({15'h0, interrupt_out_n_o}, {15'h0, lvl}, "irq");
        @(posedge mclk_i);
    endtask
    function automatic logic [15:0] word_of(input logic [2:0] c);
        return {1'b0, c, c, 9'h0a5};
    endfunction

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            $display("wrong value at %0t: run timed out", $time);
            wrap_up();
        end
    end

    initial begin
        rst_n_i = 1'b0;
        spi_cs_n_i = 1'b1;
        spi_sclk_i = 1'b0;
        spi_mosi_i = 1'b0;
        pen_present_i = 1'b1;
        pen_touch_i = 1'b0;
        mode_i = tcsr_pkg::MODE_MANUAL;
        seq_trigger_i = 1'b0;
        slow = 1'b0;
        cyc(12);
        rst_n_i <= 1'b1;
        cyc(4);
        rd_chk(tcsr_pkg::ADDR_CHAN_MASK, 8'hc0);
        rd_chk(tcsr_pkg::ADDR_STATUS, 8'h20);
        rd_chk(tcsr_pkg::ADDR_STATUS, 8'h00);
        wr_reg(tcsr_pkg::ADDR_CHAN_MASK, 8'hff);
        rd_chk(tcsr_pkg::ADDR_CHAN_MASK, 8'hf8);
        wr_reg(tcsr_pkg::ADDR_STATUS, 8'hff);
        rd_chk(tcsr_pkg::ADDR_STATUS, 8'h00);
        rd_chk(5'h10, 8'h00);
        $display("test registers done");
        // dense, sparse and odd masks; expected order from mask bits
        for (int k = 0; k < 3; k++) begin
            m = (k == 0) ? 8'hf8 : (k == 1) ? 8'h90 : 8'h28;
            wr_reg(tcsr_pkg::ADDR_CHAN_MASK, m);
            slow <= k[0];
            convert(tcsr_pkg::SEQUENCE_CODE);
            wait_irq(1'b0);
            rd_chk(tcsr_pkg::ADDR_STATUS, 8'h80);
            rd_data(6);
            n = 0;
            for (int c = 0; c < 5; c++) begin
                if (m[7-c]) begin
                    chk(got_w[n], word_of(c[2:0]), "seq word");
                    n++;
                end
            end
            chk(got_w[n], 16'hffff, "seq tail");
            wait_irq(1'b1);
        end
        $display("test sequence done");
        for (int c = 0; c < 5; c++) begin
            slow <= ~slow;
            convert(c[2:0]);
            wait_irq(1'b0);
            rd_data(2);
            chk(got_w[0], word_of(c[2:0]), "single word");
            chk(got_w[1], 16'hffff, "single tail");
        end
        pen_present_i <= 1'b0;
        convert(tcsr_pkg::CHAN_X);
        wait_irq(1'b0);
        rd_data(1);
        chk(got_w[0], 16'hffff, "no pen word");
        pen_present_i <= 1'b1;
        $display("test single done");
        pen_touch_i <= 1'b1;
        cyc(10);
        rd_chk(tcsr_pkg::ADDR_STATUS, 8'h00);
        pen_touch_i <= 1'b0;
        mode_i <= tcsr_pkg::MODE_PENDET;
        cyc(6);
        pen_touch_i <= 1'b1;
        wait_irq(1'b0);
        rd_chk(tcsr_pkg::ADDR_STATUS, 8'h40);
        rd_chk(tcsr_pkg::ADDR_STATUS, 8'h00);
        wait_irq(1'b1);
        pen_touch_i <= 1'b0;
        mode_i <= tcsr_pkg::MODE_AUTO;
        seq_trigger_i <= 1'b1;
        cyc(1);
        seq_trigger_i <= 1'b0;
        wait_irq(1'b0);
        rd_data(1);
        chk(got_w[0], word_of(tcsr_pkg::CHAN_P1), "trig word");
        $display("test pen done");
        wr_reg(tcsr_pkg::ADDR_CHAN_MASK, 8'h08);
        wr_reg(tcsr_pkg::ADDR_SOFT_RESET, 8'h55);
        rd_chk(tcsr_pkg::ADDR_CHAN_MASK, 8'h08);
        wr_reg(tcsr_pkg::ADDR_SOFT_RESET, 8'hde);
        rd_chk(tcsr_pkg::ADDR_CHAN_MASK, 8'hc0);
        rd_chk(tcsr_pkg::ADDR_STATUS, 8'h20);
        $display("test soft reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
